// ---- design/vic_pkg.sv ----
// vic_pkg: constants, register map and state codes of the vectored interrupt controller.
// assumes an 8-bit core with a 125 MHz clock and an 8-bit i/o address space.
// Overview of operation
// - enable register at i/o address 0x20
// - reset clears every enable bit
// - enable bits: 7 wake,6 pins,4/3 usb,2/1 timers
// - events from pins, wake pin, timer, usb
// - one pending latch per source, set on event
// - pending holds until serviced or reset
// - pending requests only while enabled
// - highest priority taken after current instruction
// - requests sampled on instruction's last cycle
// - ack clears enables, then pending, then calls
// - call pushes pc with carry and zero
// - returns restore pc/flags; irq return re-enables
// - vector 0 highest, 7 lowest, two bytes each
// - call takes 10 cycles, table jump 5
// - handler may re-enable, allowing nested interrupts
// - pin polarity 0 falling edge, 1 rising
// - wake pin rising edge sets masked pending
// - pin ack clears pin latch and enable bit
package vic_pkg;
    localparam logic [7:0] VIC_ADDR_ENABLE   = 8'h20;
    localparam logic [7:0] VIC_ADDR_P0_IE    = 8'h04;
    localparam logic [7:0] VIC_ADDR_P1_IE    = 8'h05;
    localparam logic [7:0] VIC_ADDR_P0_POL   = 8'h08;
    localparam logic [7:0] VIC_ADDR_P1_POL   = 8'h09;
    localparam logic [7:0] VIC_ENABLE_RESET  = 8'h00;
    localparam logic [7:0] VIC_ENABLE_MASK   = 8'hde;
    localparam logic [7:0] VIC_PORT_RESET    = 8'h00;
    localparam int         VIC_BIT_SHORT     = 1;
    localparam int         VIC_BIT_MS        = 2;
    localparam int         VIC_BIT_EP0       = 3;
    localparam int         VIC_BIT_EP1       = 4;
    localparam int         VIC_BIT_PINS      = 6;
    localparam int         VIC_BIT_WAKE      = 7;
    localparam int         VIC_VEC_STRIDE    = 2;
    localparam int         VIC_CALL_CYCLES   = 10;
    localparam int         VIC_JUMP_CYCLES   = 5;
    localparam logic [3:0] VIC_CALL_COUNT    = 4'(VIC_CALL_CYCLES - 3);
    localparam int         VIC_PC_W          = 12;

    typedef enum logic [3:0] {
        VIC_ST_IDLE     = 4'h1,
        VIC_ST_CLR_EN   = 4'h2,
        VIC_ST_CLR_PEND = 4'h4,
        VIC_ST_CALL     = 4'h8
    } vic_state_e;
endpackage

// ---- design/vic_pin_if.sv ----
// vic_pin_if: carries pin trigger settings and the merged pin event.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface vic_pin_if;
    logic [15:0] polarity;
    logic [15:0] enable;
    logic        event_pulse;
    modport ctrl (output polarity, output enable, input event_pulse);
    modport edge_det (input polarity, input enable, output event_pulse);
endinterface
`default_nettype wire

// ---- design/vic_pin_edge.sv ----
// vic_pin_edge: synchronises the 16 port pins and forms the merged pin event.
// assumes pins are asynchronous; settings come from the controller's clock domain.
`timescale 1ns/10ps
`default_nettype none
module vic_pin_edge
    import vic_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // pins
    input  wire logic [15:0] pins_i,
    // controller side
    vic_pin_if.edge_det      pin
);
    logic [15:0] meta_reg;
    logic [15:0] sync_reg;
    logic [15:0] active;
    logic        any_reg;
    logic        event_reg;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            meta_reg <= 16'h0000;
            sync_reg <= 16'h0000;
        end
        else
        begin
            meta_reg <= pins_i;
            sync_reg <= meta_reg;
        end
    end

    // per pin: trigger level chosen by polarity, gated by its enable
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_pin
            assign active[g] = pin.enable[g] &
                (pin.polarity[g] ? sync_reg[g] : ~sync_reg[g]);
        end
    endgenerate

    // a new event only when the or of all active pins rises
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            any_reg   <= 1'b1;
            event_reg <= 1'b0;
        end
        else
        begin
            any_reg   <= |active;
            event_reg <= (|active) & ~any_reg;
        end
    end

    assign pin.event_pulse = event_reg;
endmodule
`default_nettype wire

// ---- design/vic_ctrl.sv ----
// vic_ctrl: pending latches, global enable register, priority select and acknowledge call.
// assumes the core gives i/o strobes, an end-of-instruction mark, pc and flags,
// and stalls its own fetch while CALL_BUSY_O is high.
`timescale 1ns/10ps
`default_nettype none
module vic_ctrl
    import vic_pkg::*;
(
    // clock and reset
    input  wire logic                CLK_I,
    input  wire logic                RESET_I,
    // core i/o port access
    input  wire logic [7:0]          IO_ADDR_I,
    input  wire logic [7:0]          IO_WDATA_I,
    input  wire logic                IO_WR_I,
    input  wire logic                IO_RD_I,
    output logic      [7:0]          IO_RDATA_O,
    // event sources
    input  wire logic [15:0]         PINS_I,
    input  wire logic                WAKE_PIN_I,
    input  wire logic                SHORT_TICK_I,
    input  wire logic                MS_TICK_I,
    input  wire logic                USB_EP0_I,
    input  wire logic                USB_EP1_I,
    // core sequencing
    input  wire logic                INSTR_LAST_I,
    input  wire logic [VIC_PC_W-1:0] PC_I,
    input  wire logic                CARRY_FLAG_I,
    input  wire logic                ZERO_FLAG_I,
    input  wire logic                RET_I,
    input  wire logic                IRQ_RETURN_INSTR_I,
    // to core
    output logic                     IRQ_REQ_O,
    output logic      [2:0]          IRQ_INDEX_O,
    output logic                     CALL_BUSY_O,
    output logic                     PUSH_O,
    output logic [VIC_PC_W+1:0]      PUSH_DATA_O,
    output logic                     PC_LOAD_O,
    output logic [VIC_PC_W-1:0]      PC_VECTOR_O,
    output logic                     RESTORE_FLAGS_O
);
    vic_pin_if pin ();

    logic [7:0]       global_irq_enable_reg;
    logic [7:0]       enable_shadow_reg;
    logic [7:0]       pending_reg;
    logic [7:0]       events;
    logic [7:0]       requests;
    logic [2:0]       sel_index;
    logic             sel_valid;
    logic [15:0]      pin_polarity_reg;
    logic [15:0]      pin_enable_reg;
    logic             wake_meta_reg;
    logic             wake_sync_reg;
    logic             wake_prev_reg;
    vic_state_e       state_reg;
    logic [3:0]       call_cnt_reg;
    logic [2:0]       ack_index_reg;
    logic             wr_enable;

    vic_pin_edge u_pin_edge (
        .clk_i   (CLK_I),
        .reset_i (RESET_I),
        .pins_i  (PINS_I),
        .pin     (pin.edge_det)
    );

    assign pin.polarity = pin_polarity_reg;
    assign pin.enable   = pin_enable_reg;
    assign wr_enable    = IO_WR_I && (IO_ADDR_I == VIC_ADDR_ENABLE);

    // wake pin synchroniser and rising edge
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            wake_meta_reg <= 1'b1;
            wake_sync_reg <= 1'b1;
            wake_prev_reg <= 1'b1;
        end
        else
        begin
            wake_meta_reg <= WAKE_PIN_I;
            wake_sync_reg <= wake_meta_reg;
            wake_prev_reg <= wake_sync_reg;
        end
    end

    // event vector, one bit per priority slot
    always_comb
    begin
        events                = 8'h00;
        events[VIC_BIT_SHORT] = SHORT_TICK_I;
        events[VIC_BIT_MS]    = MS_TICK_I;
        events[VIC_BIT_EP0]   = USB_EP0_I;
        events[VIC_BIT_EP1]   = USB_EP1_I;
        events[VIC_BIT_PINS]  = pin.event_pulse;
        events[VIC_BIT_WAKE]  = wake_sync_reg & ~wake_prev_reg;
    end

    // port trigger polarity, write-only
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            pin_polarity_reg <= {2{VIC_PORT_RESET}};
        end
        else if (IO_WR_I && IO_ADDR_I == VIC_ADDR_P0_POL)
        begin
            pin_polarity_reg[7:0] <= IO_WDATA_I;
        end
        else if (IO_WR_I && IO_ADDR_I == VIC_ADDR_P1_POL)
        begin
            pin_polarity_reg[15:8] <= IO_WDATA_I;
        end
    end

    // per-pin trigger enables, write-only
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            pin_enable_reg <= {2{VIC_PORT_RESET}};
        end
        else if (IO_WR_I && IO_ADDR_I == VIC_ADDR_P0_IE)
        begin
            pin_enable_reg[7:0] <= IO_WDATA_I;
        end
        else if (IO_WR_I && IO_ADDR_I == VIC_ADDR_P1_IE)
        begin
            pin_enable_reg[15:8] <= IO_WDATA_I;
        end
    end

    // global enable register; hardware clear on acknowledge beats a write
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            global_irq_enable_reg <= VIC_ENABLE_RESET;
        end
        else if (state_reg == VIC_ST_CLR_EN)
        begin
            global_irq_enable_reg <= VIC_ENABLE_RESET;
        end
        else if (wr_enable)
        begin
            global_irq_enable_reg <= IO_WDATA_I & VIC_ENABLE_MASK;
        end
        else if (IRQ_RETURN_INSTR_I)
        begin
            global_irq_enable_reg <= enable_shadow_reg;
        end
    end

    // enable value seen at acknowledge, put back by the irq return
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            enable_shadow_reg <= VIC_ENABLE_RESET;
        end
        else if (state_reg == VIC_ST_CLR_EN)
        begin
            enable_shadow_reg <= global_irq_enable_reg;
        end
    end

    // pending latches: a new event wins over the service clear
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            pending_reg <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (events[i] && VIC_ENABLE_MASK[i])
                begin
                    pending_reg[i] <= 1'b1;
                end
                else if (state_reg == VIC_ST_CLR_PEND && ack_index_reg == 3'(i))
                begin
                    pending_reg[i] <= 1'b0;
                end
            end
        end
    end

    assign requests = pending_reg & global_irq_enable_reg;

    // lowest slot number wins; slot 0 is reset and never pends
    always_comb
    begin
        sel_index = 3'h0;
        sel_valid = 1'b0;
        for (int i = 7; i >= 1; i--)
        begin
            if (requests[i])
            begin
                sel_index = 3'(i);
                sel_valid = 1'b1;
            end
        end
    end

    // acknowledge sequence: clear enables, clear latch, finish the call
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            state_reg     <= VIC_ST_IDLE;
            call_cnt_reg  <= 4'h0;
            ack_index_reg <= 3'h0;
        end
        else
        begin
            case (state_reg)
                VIC_ST_IDLE:
                begin
                    if (INSTR_LAST_I && sel_valid)
                    begin
                        ack_index_reg <= sel_index;
                        state_reg     <= VIC_ST_CLR_EN;
                    end
                end
                VIC_ST_CLR_EN:
                begin
                    state_reg <= VIC_ST_CLR_PEND;
                end
                VIC_ST_CLR_PEND:
                begin
                    call_cnt_reg <= VIC_CALL_COUNT;
                    state_reg    <= VIC_ST_CALL;
                end
                VIC_ST_CALL:
                begin
                    if (call_cnt_reg == 4'h0)
                    begin
                        state_reg <= VIC_ST_IDLE;
                    end
                    else
                    begin
                        call_cnt_reg <= call_cnt_reg - 4'h1;
                    end
                end
                default:
                begin
                    state_reg <= VIC_ST_IDLE;
                end
            endcase
        end
    end

    // request level and index seen by the core
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            IRQ_REQ_O   <= 1'b0;
            IRQ_INDEX_O <= 3'h0;
        end
        else
        begin
            IRQ_REQ_O   <= sel_valid;
            IRQ_INDEX_O <= sel_index;
        end
    end

    // core stall from the acknowledge edge until the last call count
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            CALL_BUSY_O <= 1'b0;
        end
        else
        begin
            CALL_BUSY_O <= (state_reg == VIC_ST_IDLE) ? (INSTR_LAST_I && sel_valid)
                           : !(state_reg == VIC_ST_CALL && call_cnt_reg == 4'h0);
        end
    end

    // stack push of pc and flags sampled in the latch-clear cycle, strobed the cycle after
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            PUSH_O      <= 1'b0;
            PUSH_DATA_O <= '0;
        end
        else
        begin
            PUSH_O <= (state_reg == VIC_ST_CLR_PEND);
            if (state_reg == VIC_ST_CLR_PEND)
            begin
                PUSH_DATA_O <= {ZERO_FLAG_I, CARRY_FLAG_I, PC_I};
            end
        end
    end

    // vector load once the call has run its cycles
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            PC_LOAD_O   <= 1'b0;
            PC_VECTOR_O <= '0;
        end
        else
        begin
            PC_LOAD_O   <= (state_reg == VIC_ST_CALL) && (call_cnt_reg == 4'h0);
            PC_VECTOR_O <= VIC_PC_W'(ack_index_reg) * VIC_PC_W'(VIC_VEC_STRIDE);
        end
    end

    // flag restore one cycle after either return
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            RESTORE_FLAGS_O <= 1'b0;
        end
        else
        begin
            RESTORE_FLAGS_O <= RET_I | IRQ_RETURN_INSTR_I;
        end
    end

    // register read, reserved bits read zero
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            IO_RDATA_O <= 8'h00;
        end
        else if (IO_RD_I && IO_ADDR_I == VIC_ADDR_ENABLE)
        begin
            IO_RDATA_O <= global_irq_enable_reg;
        end
        else
        begin
            IO_RDATA_O <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/vic_chk.sv ----
// vic_chk: concurrent checks on the ports of vic_ctrl.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module vic_chk
    import vic_pkg::*;
(
    // clock and reset
    input wire logic                CLK_I,
    input wire logic                RESET_I,
    // i/o port
    input wire logic [7:0]          IO_ADDR_I,
    input wire logic                IO_RD_I,
    input wire logic [7:0]          IO_RDATA_O,
    // core sequencing
    input wire logic                INSTR_LAST_I,
    input wire logic [VIC_PC_W-1:0] PC_I,
    input wire logic                CARRY_FLAG_I,
    input wire logic                ZERO_FLAG_I,
    input wire logic                RET_I,
    input wire logic                IRQ_RETURN_INSTR_I,
    // to core
    input wire logic                IRQ_REQ_O,
    input wire logic [2:0]          IRQ_INDEX_O,
    input wire logic                CALL_BUSY_O,
    input wire logic                PUSH_O,
    input wire logic [VIC_PC_W+1:0] PUSH_DATA_O,
    input wire logic                PC_LOAD_O,
    input wire logic [VIC_PC_W-1:0] PC_VECTOR_O,
    input wire logic                RESTORE_FLAGS_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    property p_start;
        $rose(CALL_BUSY_O) |-> $past(INSTR_LAST_I);
    endproperty
    a_start: assert property (p_start) else $error("call began off an instruction end");
    property p_call_len;
        $rose(CALL_BUSY_O) |-> CALL_BUSY_O[*8] ##1 CALL_BUSY_O ##1 CALL_BUSY_O
            ##1 (PC_LOAD_O && !CALL_BUSY_O);
    endproperty
    a_call_len: assert property (p_call_len) else $error("call length wrong");
    property p_push_time;
        $rose(CALL_BUSY_O) |-> !PUSH_O ##1 !PUSH_O ##1 PUSH_O ##1 !PUSH_O;
    endproperty
    a_push_time: assert property (p_push_time) else $error("push pulse misplaced");
    property p_push_data;
        PUSH_O |-> PUSH_DATA_O == {$past(ZERO_FLAG_I), $past(CARRY_FLAG_I), $past(PC_I)};
    endproperty
    a_push_data: assert property (p_push_data) else $error("pushed pc or flags wrong");
    property p_vector;
        PC_LOAD_O |-> PC_VECTOR_O == {8'h00, $past(IRQ_INDEX_O, 10), 1'b0};
    endproperty
    a_vector: assert property (p_vector) else $error("vector not twice the index");
    property p_restore;
        RESTORE_FLAGS_O == $past(RET_I || IRQ_RETURN_INSTR_I);
    endproperty
    a_restore: assert property (p_restore) else $error("flag restore mistimed");
    property p_rdata;
        IO_RDATA_O != 8'h00 |-> $past(IO_RD_I) && $past(IO_ADDR_I) == VIC_ADDR_ENABLE
            && (IO_RDATA_O & ~VIC_ENABLE_MASK) == 8'h00;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data from wrong place");
    property p_req;
        IRQ_REQ_O == (IRQ_INDEX_O != 3'h0) && IRQ_INDEX_O != 3'h5;
    endproperty
    a_req: assert property (p_req) else $error("request and index disagree");

    c_call: cover property ($rose(CALL_BUSY_O));
    c_push: cover property (PUSH_O);
    c_restore: cover property (RESTORE_FLAGS_O);
endmodule
bind vic_ctrl vic_chk i_vic_chk (.CLK_I(CLK_I), .RESET_I(RESET_I), .IO_ADDR_I(IO_ADDR_I),
    .IO_RD_I(IO_RD_I), .IO_RDATA_O(IO_RDATA_O), .INSTR_LAST_I(INSTR_LAST_I), .PC_I(PC_I),
    .CARRY_FLAG_I(CARRY_FLAG_I), .ZERO_FLAG_I(ZERO_FLAG_I), .RET_I(RET_I),
    .IRQ_RETURN_INSTR_I(IRQ_RETURN_INSTR_I), .IRQ_REQ_O(IRQ_REQ_O), .IRQ_INDEX_O(IRQ_INDEX_O),
    .CALL_BUSY_O(CALL_BUSY_O), .PUSH_O(PUSH_O), .PUSH_DATA_O(PUSH_DATA_O),
    .PC_LOAD_O(PC_LOAD_O), .PC_VECTOR_O(PC_VECTOR_O), .RESTORE_FLAGS_O(RESTORE_FLAGS_O));
`default_nettype wire

// ---- testbench/vic_core_model.sv ----
// vic_core_model: core sequencing, four-cycle instructions, stalls during the call.
// assumes the controller's outputs settle by the falling edge.
`timescale 1ns/10ps
`default_nettype none
module vic_core_model
    import vic_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    // from controller
    input  wire logic                busy_i,
    input  wire logic                load_i,
    input  wire logic [VIC_PC_W-1:0] vector_i,
    // to controller
    output var logic                 last_o,
    output var logic  [VIC_PC_W-1:0] pc_o,
    output logic                     carry_o,
    output logic                     zero_o
);
    logic [1:0] phase;
    initial
    begin
        last_o = 1'b0;
        pc_o = 12'h000;
        phase = 2'h0;
    end
    assign carry_o = pc_o[0];
    assign zero_o = pc_o[1];
    // fetch holds while the call runs, then jumps to the vector
    always @(negedge clk_i)
    begin
        if (reset_i || busy_i)
            last_o <= 1'b0;
        else if (load_i)
        begin
            pc_o <= vector_i;
            phase <= 2'h0;
            last_o <= 1'b0;
        end
        else
        begin
            phase <= phase + 2'h1;
            last_o <= phase == 2'h2;
            if (phase == 2'h3)
                pc_o <= pc_o + 12'h001;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// tb_top: register, priority, pin and wake checks of vic_ctrl.
// assumes vic_core_model runs the core side; inputs change on falling edges.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import vic_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, wake = 1'b1, ret = 1'b0, iret = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] pins = 16'h0001;
    logic [3:0] ev = 4'h0;
    logic il, cf, zf, req, busy, push, load, rest;
    logic [2:0] idx;
    logic [13:0] pd;
    logic [11:0] pc, vec;
    int num_errors = 0, check_count = 0;
    always #4 clk = ~clk;
    vic_ctrl i_vic_ctrl (.CLK_I(clk), .RESET_I(rst), .IO_ADDR_I(addr), .IO_WDATA_I(wdata),
        .IO_WR_I(wr), .IO_RD_I(rd), .IO_RDATA_O(rdata), .PINS_I(pins), .WAKE_PIN_I(wake),
        .SHORT_TICK_I(ev[0]), .MS_TICK_I(ev[1]), .USB_EP0_I(ev[2]), .USB_EP1_I(ev[3]),
        .INSTR_LAST_I(il), .PC_I(pc), .CARRY_FLAG_I(cf), .ZERO_FLAG_I(zf), .RET_I(ret),
        .IRQ_RETURN_INSTR_I(iret), .IRQ_REQ_O(req), .IRQ_INDEX_O(idx), .CALL_BUSY_O(busy),
        .PUSH_O(push), .PUSH_DATA_O(pd), .PC_LOAD_O(load), .PC_VECTOR_O(vec),
        .RESTORE_FLAGS_O(rest));
    vic_core_model i_vic_core_model (.clk_i(clk), .reset_i(rst), .busy_i(busy), .load_i(load),
        .vector_i(vec), .last_o(il), .pc_o(pc), .carry_o(cf), .zero_o(zf));

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("read data", {6'h00, rdata}, {6'h00, exp});
    endtask
    // enable the given sources, wait for the call, check vector and cleared enables
    task automatic serve(input logic [7:0] en, input logic [11:0] exp_vec);
        int n;
        io_wr(VIC_ADDR_ENABLE, en);
        for (n = 0; n < 80 && load !== 1'b1; n++)
            @(negedge clk);
        if (load !== 1'b1)
        begin
            num_errors++;
            test_done();
        end
        chk("vector", {2'h0, vec}, {2'h0, exp_vec});
        rd_chk(VIC_ADDR_ENABLE, 8'h00);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    initial
    begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        rd_chk(VIC_ADDR_ENABLE, VIC_ENABLE_RESET);
        chk("request", {13'h0, req}, 14'h0);
        io_wr(VIC_ADDR_ENABLE, 8'hff);
        rd_chk(VIC_ADDR_ENABLE, 8'hde);
        io_wr(VIC_ADDR_P0_POL, 8'hff);
        rd_chk(VIC_ADDR_P0_POL, 8'h00);
        rd_chk(8'h33, 8'h00);
        io_wr(VIC_ADDR_ENABLE, 8'h00);
        io_wr(VIC_ADDR_P0_POL, 8'h00);
        $display("end of register test");
        // all four pulse sources pend while masked, then drain in priority order
        @(negedge clk);
        ev = 4'hf;
        @(negedge clk);
        ev = 4'h0;
        repeat (6) @(negedge clk);
        chk("masked request", {13'h0, req}, 14'h0);
        for (int b = 1; b <= 4; b++)
            serve((8'h1f >> b) << b, 12'(2 * b));
        pulse(iret);
        rd_chk(VIC_ADDR_ENABLE, 8'h10);
        pulse(ret);
        chk("restore", {13'h0, rest}, 14'h1);
        io_wr(VIC_ADDR_ENABLE, 8'h00);
        $display("end of priority test");
        // rising trigger on a port 1 pin, then falling trigger on a port 0 pin
        io_wr(VIC_ADDR_ENABLE, 8'h40);
        io_wr(VIC_ADDR_P1_POL, 8'h01);
        io_wr(VIC_ADDR_P1_IE, 8'h01);
        repeat (3) @(negedge clk);
        chk("pin low idle", {13'h0, req}, 14'h0);
        pins[8] = 1'b1;
        serve(8'h40, 12'h00c);
        io_wr(VIC_ADDR_ENABLE, 8'h40);
        repeat (8) @(negedge clk);
        chk("pin pending", {13'h0, req}, 14'h0);
        io_wr(VIC_ADDR_P1_IE, 8'h00);
        io_wr(VIC_ADDR_P0_IE, 8'h01);
        repeat (3) @(negedge clk);
        chk("pin high idle", {13'h0, req}, 14'h0);
        pins[0] = 1'b0;
        serve(8'h40, 12'h00c);
        $display("end of pin test");
        io_wr(VIC_ADDR_ENABLE, 8'h80);
        wake = 1'b0;
        repeat (4) @(negedge clk);
        chk("wake fall", {13'h0, req}, 14'h0);
        wake = 1'b1;
        serve(8'h80, 12'h00e);
        $display("end of wake test");
        test_done();
    end
endmodule
`default_nettype wire
